// >>> core/lsr_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module lsr_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    input  wire logic [WIDTH-1:0] raw_in,
    output logic      [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock_in) begin
            if (!nrst_in) begin
                stable_out[i] <= 1'b0;
            end else if (s2_q[i] == s3_q[i]) begin
                stable_out[i] <= s3_q[i];
            end
        end
    end
endmodule

// >>> core/lsr_regfile.sv
// configuration registers with held read pointer
`timescale 1ns/1ns
module lsr_regfile (
    input  wire logic                   clock_in,
    input  wire logic                   nrst_in,
    input  wire logic                   clear_n_in,
    input  wire logic                   ptr_wr_in,
    input  wire logic                   data_wr_in,
    input  wire logic [7:0]             data_in,
    output logic      [lsr_pkg::NUM_REGS-1:0][7:0] regs_out,
    output logic      [7:0]             rdata_out
);
    logic [7:0] ptr_q;

    function automatic logic [7:0] wmask(input logic [7:0] addr);
        unique case (addr)
            lsr_pkg::ADDR_MASK:  wmask = lsr_pkg::MASK_WMASK;
            lsr_pkg::ADDR_CFG_A,
            lsr_pkg::ADDR_CFG_B,
            lsr_pkg::ADDR_CFG_C: wmask = lsr_pkg::CFG_WMASK;
            lsr_pkg::ADDR_ROUTE: wmask = lsr_pkg::ROUTE_WMASK;
            default:             wmask = 8'h00;
        endcase
    endfunction

    always_ff @(posedge clock_in) begin
        if (!nrst_in || !clear_n_in) begin
            ptr_q <= 8'h00;
        end else if (ptr_wr_in) begin
            ptr_q <= data_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in || !clear_n_in) begin
            regs_out <= {lsr_pkg::NUM_REGS{lsr_pkg::REG_RESET}};
        end else if (data_wr_in && ptr_q < 8'(lsr_pkg::NUM_REGS)) begin
            regs_out[ptr_q[2:0]] <= data_in & wmask(ptr_q);
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            rdata_out <= 8'h00;
        end else if (ptr_q < 8'(lsr_pkg::NUM_REGS)) begin
            rdata_out <= regs_out[ptr_q[2:0]];
        end else begin
            rdata_out <= 8'h00;
        end
    end
endmodule

// >>> core/lsr_route_ctrl.sv
// lane switch route control: source select, routing and port settings
`timescale 1ns/1ns
module lsr_route_ctrl (
    input  wire logic             clock_in,
    input  wire logic             nrst_in,
    input  wire logic             mode_pin_in,
    input  wire logic             sel_pin_in,
    input  wire logic             dual_copy_pin_in,
    input  wire logic             port_a_loop_enable_in,
    input  wire logic             port_b_loop_enable_in,
    input  wire logic             port_c_loop_enable_in,
    input  wire logic             port_a_rx_boost_in,
    input  wire logic             port_b_rx_boost_in,
    input  wire logic             port_c_rx_boost_in,
    input  wire logic             port_a_tx_emphasis_in,
    input  wire logic             port_b_tx_emphasis_in,
    input  wire logic             port_c_tx_emphasis_in,
    input  wire logic             config_reset_n_in,
    input  wire logic             reg_ptr_wr_in,
    input  wire logic             reg_data_wr_in,
    input  wire logic [7:0]       reg_data_in,
    output lsr_pkg::lsr_src_e     out_a_src_out,
    output lsr_pkg::lsr_src_e     out_b_src_out,
    output lsr_pkg::lsr_src_e     out_c_src_out,
    output logic                  port_a_idle_out,
    output logic                  port_b_idle_out,
    output logic                  port_c_idle_out,
    output logic                  port_a_rx_boost_out,
    output logic                  port_b_rx_boost_out,
    output logic                  port_c_rx_boost_out,
    output logic      [1:0]       port_a_tx_emphasis_out,
    output logic      [1:0]       port_b_tx_emphasis_out,
    output logic      [1:0]       port_c_tx_emphasis_out,
    output logic      [7:0]       reg_rdata_out
);
    localparam int NP = lsr_pkg::NUM_PORTS;

    logic [lsr_pkg::PIN_COUNT-1:0]       pin_raw;
    logic [lsr_pkg::PIN_COUNT-1:0]       pin_s;
    logic [lsr_pkg::NUM_REGS-1:0][7:0]   regs;
    logic [7:0]                          mask_r;
    logic [7:0]                          route_r;
    logic                                serial;
    logic                                eff_sel;
    logic                                eff_dual;
    logic [NP-1:0]                       eff_loop;
    logic [NP-1:0]                       eff_eq;
    logic [NP-1:0]                       eff_dis;
    logic [NP-1:0][1:0]                  eff_pe;
    lsr_pkg::lsr_src_e                   src_d [NP];
    lsr_pkg::lsr_src_e                   src_q [NP];
    logic [NP-1:0]                       idle_q;
    logic [NP-1:0]                       eq_q;
    logic [NP-1:0][1:0]                  pe_q;

    assign pin_raw = {config_reset_n_in,
                      port_c_tx_emphasis_in,
                      port_b_tx_emphasis_in,
                      port_a_tx_emphasis_in,
                      port_c_rx_boost_in,
                      port_b_rx_boost_in,
                      port_a_rx_boost_in,
                      port_c_loop_enable_in,
                      port_b_loop_enable_in,
                      port_a_loop_enable_in,
                      dual_copy_pin_in,
                      sel_pin_in,
                      mode_pin_in};

    // pins come from the board, never read raw
    lsr_pin_sync #(
        .WIDTH (lsr_pkg::PIN_COUNT)
    ) u_sync (
        .clock_in   (clock_in),
        .nrst_in    (nrst_in),
        .raw_in     (pin_raw),
        .stable_out (pin_s)
    );

    lsr_regfile u_regs (
        .clock_in   (clock_in),
        .nrst_in    (nrst_in),
        .clear_n_in (pin_s[lsr_pkg::PIN_CFG_RST]),
        .ptr_wr_in  (reg_ptr_wr_in),
        .data_wr_in (reg_data_wr_in),
        .data_in    (reg_data_in),
        .regs_out   (regs),
        .rdata_out  (reg_rdata_out)
    );

    assign mask_r  = regs[lsr_pkg::ADDR_MASK[2:0]];
    assign route_r = regs[lsr_pkg::ADDR_ROUTE[2:0]];
    assign serial  = pin_s[lsr_pkg::PIN_MODE];

    // switching source: pin unless serial mode and mask set
    assign eff_sel = (serial && mask_r[lsr_pkg::MASK_SEL])
                   ? route_r[lsr_pkg::ROUTE_SEL]
                   : pin_s[lsr_pkg::PIN_SEL];
    assign eff_dual = (serial && mask_r[lsr_pkg::MASK_DUAL])
                    ? route_r[lsr_pkg::ROUTE_DUAL]
                    : pin_s[lsr_pkg::PIN_DUAL];

    for (genvar p = 0; p < NP; p++) begin : g_port
        logic [7:0] cfg;
        assign cfg = regs[3'(lsr_pkg::ADDR_CFG_A) + 3'(p)];
        assign eff_loop[p] = (serial && mask_r[lsr_pkg::MASK_LOOP_A + p])
                           ? cfg[lsr_pkg::CFG_LB]
                           : pin_s[lsr_pkg::PIN_LOOP_A + p];
        assign eff_eq[p] = serial ? cfg[lsr_pkg::CFG_EQ]
                         : pin_s[lsr_pkg::PIN_BOOST_A + p];
        assign eff_pe[p] = serial
                         ? cfg[lsr_pkg::CFG_PE_HI:lsr_pkg::CFG_PE_LO]
                         : (pin_s[lsr_pkg::PIN_EMPH_A + p]
                            ? lsr_pkg::PE_PIN_ON
                            : lsr_pkg::PE_OFF);
        // disable is a serial-only feature
        assign eff_dis[p] = serial && cfg[lsr_pkg::CFG_DIS];
    end

    // disable first, then loopback, then routing condition, else fallback
    function automatic lsr_pkg::lsr_src_e pick(
        input logic              loop,
        input lsr_pkg::lsr_src_e loop_src,
        input logic              cond,
        input lsr_pkg::lsr_src_e cond_src,
        input lsr_pkg::lsr_src_e else_src,
        input logic              dis
    );
        if (dis) begin
            pick = lsr_pkg::LSR_SRC_IDLE;
        end else if (loop) begin
            pick = loop_src;
        end else if (cond) begin
            pick = cond_src;
        end else begin
            pick = else_src;
        end
    endfunction

    always_comb begin
        src_d[0] = pick(eff_loop[0], lsr_pkg::LSR_SRC_A,
                        !eff_sel || eff_dual, lsr_pkg::LSR_SRC_C,
                        lsr_pkg::LSR_SRC_IDLE, eff_dis[0]);
        src_d[1] = pick(eff_loop[1], lsr_pkg::LSR_SRC_B,
                        eff_sel || eff_dual, lsr_pkg::LSR_SRC_C,
                        lsr_pkg::LSR_SRC_IDLE, eff_dis[1]);
        src_d[2] = pick(eff_loop[2], lsr_pkg::LSR_SRC_C,
                        eff_sel, lsr_pkg::LSR_SRC_B,
                        lsr_pkg::LSR_SRC_A, eff_dis[2]);
    end

    // one register stage so outputs come straight from flops
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            for (int p = 0; p < NP; p++) begin
                src_q[p] <= lsr_pkg::LSR_SRC_IDLE;
            end
            idle_q <= '1;
        end else begin
            for (int p = 0; p < NP; p++) begin
                src_q[p] <= src_d[p];
                idle_q[p] <= (src_d[p] == lsr_pkg::LSR_SRC_IDLE);
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            eq_q <= '0;
            pe_q <= '0;
        end else begin
            eq_q <= eff_eq;
            pe_q <= eff_pe;
        end
    end

    assign out_a_src_out          = src_q[0];
    assign out_b_src_out          = src_q[1];
    assign out_c_src_out          = src_q[2];
    assign port_a_idle_out        = idle_q[0];
    assign port_b_idle_out        = idle_q[1];
    assign port_c_idle_out        = idle_q[2];
    assign port_a_rx_boost_out    = eq_q[0];
    assign port_b_rx_boost_out    = eq_q[1];
    assign port_c_rx_boost_out    = eq_q[2];
    assign port_a_tx_emphasis_out = pe_q[0];
    assign port_b_tx_emphasis_out = pe_q[1];
    assign port_c_tx_emphasis_out = pe_q[2];

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!nrst_in);

    a_out_a_loop: assert property (
        eff_loop[0] && !eff_dis[0] |=> out_a_src_out == lsr_pkg::LSR_SRC_A
    ) else $error("output A not looped back");

    a_out_a_route: assert property (
        !eff_loop[0] && !eff_dis[0] && (!eff_sel || eff_dual)
        |=> out_a_src_out == lsr_pkg::LSR_SRC_C
    ) else $error("output A not fed from input C");

    a_unsel_idle: assert property (
        !eff_loop[0] && eff_sel && !eff_dual
        |=> out_a_src_out == lsr_pkg::LSR_SRC_IDLE && port_a_idle_out
    ) else $error("unselected output A not idle");

    a_out_b_route: assert property (
        !eff_dis[1] |=> out_b_src_out == (
            $past(eff_loop[1]) ? lsr_pkg::LSR_SRC_B :
            ($past(eff_sel) || $past(eff_dual)) ? lsr_pkg::LSR_SRC_C :
            lsr_pkg::LSR_SRC_IDLE)
    ) else $error("output B routed wrongly");

    a_out_c_route: assert property (
        !eff_loop[2] && !eff_dis[2] |=> out_c_src_out ==
            ($past(eff_sel) ? lsr_pkg::LSR_SRC_B : lsr_pkg::LSR_SRC_A)
    ) else $error("output C routed wrongly");

    a_disable_idle: assert property (
        eff_dis[2] |=> port_c_idle_out && out_c_src_out ==
            lsr_pkg::LSR_SRC_IDLE
    ) else $error("disabled output C not idle");

    a_idle_flag: assert property (
        port_b_idle_out == (out_b_src_out == lsr_pkg::LSR_SRC_IDLE)
    ) else $error("idle flag disagrees with source");

    a_pin_emphasis: assert property (
        !serial ##1 !serial |-> port_a_tx_emphasis_out ==
            ($past(pin_s[lsr_pkg::PIN_EMPH_A]) ? 2'h2 : 2'h0)
    ) else $error("pin emphasis code wrong");

    a_serial_boost: assert property (
        serial |=> port_b_rx_boost_out ==
            $past(regs[2][lsr_pkg::CFG_EQ])
    ) else $error("serial boost not from register");

    a_mask_sel: assert property (
        serial && mask_r[lsr_pkg::MASK_SEL] && !eff_loop[2] && !eff_dis[2]
        |=> out_c_src_out == ($past(route_r[0]) ? lsr_pkg::LSR_SRC_B
                                                 : lsr_pkg::LSR_SRC_A)
    ) else $error("select not taken from register");

    a_pin_mode_sel: assert property (
        !serial && !eff_loop[2] |=> out_c_src_out ==
            ($past(pin_s[lsr_pkg::PIN_SEL]) ? lsr_pkg::LSR_SRC_B
                                            : lsr_pkg::LSR_SRC_A)
    ) else $error("pin mode select not from pin");

    a_cfg_clear: assert property (
        !pin_s[lsr_pkg::PIN_CFG_RST] |=> regs == '0
    ) else $error("registers not cleared by reset pin");

    a_out_c_loop: assert property (
        eff_loop[2] && !eff_dis[2] |=> out_c_src_out == lsr_pkg::LSR_SRC_C
    ) else $error("output C not looped back");

    a_dual_copy: assert property (
        eff_dual && !(|eff_loop[1:0]) && !(|eff_dis[1:0])
        |=> out_a_src_out == lsr_pkg::LSR_SRC_C
            && out_b_src_out == lsr_pkg::LSR_SRC_C
    ) else $error("dual copy not fed to both outputs");

    a_unsel_b_idle: assert property (
        !eff_loop[1] && !eff_sel && !eff_dual
        |=> out_b_src_out == lsr_pkg::LSR_SRC_IDLE && port_b_idle_out
    ) else $error("unselected output B not idle");

    a_pin_boost: assert property (
        !serial |=> port_c_rx_boost_out ==
            $past(pin_s[lsr_pkg::PIN_BOOST_A + 2])
    ) else $error("pin boost not from pin");

    a_reg_emphasis: assert property (
        serial |=> port_c_tx_emphasis_out ==
            $past(regs[3][lsr_pkg::CFG_PE_HI:lsr_pkg::CFG_PE_LO])
    ) else $error("register emphasis code not applied");

    a_disable_a_idle: assert property (
        eff_dis[0] |=> port_a_idle_out && out_a_src_out ==
            lsr_pkg::LSR_SRC_IDLE
    ) else $error("disabled output A not idle");

endmodule

// >>> inc/lsr_pkg.sv
// shared constants and types for the lane switch route control
package lsr_pkg;

    // register offsets
    localparam logic [7:0] ADDR_MASK  = 8'h00;
    localparam logic [7:0] ADDR_CFG_A = 8'h01;
    localparam logic [7:0] ADDR_CFG_B = 8'h02;
    localparam logic [7:0] ADDR_CFG_C = 8'h03;
    localparam logic [7:0] ADDR_ROUTE = 8'h04;
    localparam int         NUM_REGS   = 5;
    localparam int         NUM_PORTS  = 3;

    localparam logic [7:0] REG_RESET  = 8'h00;

    // writable bits per register
    localparam logic [7:0] MASK_WMASK  = 8'h1F;
    localparam logic [7:0] CFG_WMASK   = 8'h1F;
    localparam logic [7:0] ROUTE_WMASK = 8'h03;

    // control_source_mask fields
    localparam int MASK_LOOP_A = 0;
    localparam int MASK_SEL    = 3;
    localparam int MASK_DUAL   = 4;

    // port config fields
    localparam int CFG_PE_LO = 0;
    localparam int CFG_PE_HI = 1;
    localparam int CFG_EQ    = 2;
    localparam int CFG_LB    = 3;
    localparam int CFG_DIS   = 4;

    // switch_route_control fields
    localparam int ROUTE_SEL  = 0;
    localparam int ROUTE_DUAL = 1;

    // pre-emphasis codes
    localparam logic [1:0] PE_OFF     = 2'h0;
    localparam logic [1:0] PE_PIN_ON  = 2'h2;

    // synchronised pin vector layout
    localparam int PIN_MODE    = 0;
    localparam int PIN_SEL     = 1;
    localparam int PIN_DUAL    = 2;
    localparam int PIN_LOOP_A  = 3;
    localparam int PIN_BOOST_A = 6;
    localparam int PIN_EMPH_A  = 9;
    localparam int PIN_CFG_RST = 12;
    localparam int PIN_COUNT   = 13;

    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        LSR_SRC_IDLE,
        LSR_SRC_A,
        LSR_SRC_B,
        LSR_SRC_C
    } lsr_src_e;

endpackage

// >>> verif/lsr_ctrl_model.sv
// controller and board-pin model facing the route control block
`timescale 1ns/1ns
module lsr_ctrl_model (
    input  wire logic       clock_in,
    output logic            mode_out,
    output logic            sel_out,
    output logic            dual_out,
    output logic      [2:0] loop_out,
    output logic      [2:0] boost_out,
    output logic      [2:0] emph_out,
    output logic            cfg_rst_n_out,
    output logic            ptr_wr_out,
    output logic            data_wr_out,
    output logic      [7:0] data_out
);
    initial begin
        {mode_out, sel_out, dual_out, loop_out, boost_out, emph_out} = 12'h000;
        cfg_rst_n_out = 1'b1;
        ptr_wr_out = 1'b0;
        data_wr_out = 1'b0;
        data_out = 8'hA5;
    end

    // pin vector: mode, select, dual, loop[2:0], boost[2:0], emphasis[2:0]
    task automatic pins(input logic [11:0] v);
        @(posedge clock_in);
        #1;
        {mode_out, sel_out, dual_out, loop_out, boost_out, emph_out} = v;
    endtask

    // one-cycle pointer or data strobe
    task automatic strobe(input logic p, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        ptr_wr_out = p;
        data_wr_out = !p;
        data_out = d;
        @(posedge clock_in);
        #1;
        ptr_wr_out = 1'b0;
        data_wr_out = 1'b0;
        // released byte must not look stale
        data_out = ~d;
    endtask

    task automatic cfg_reset(input int n);
        @(posedge clock_in);
        #1;
        cfg_rst_n_out = 1'b0;
        repeat (n) @(posedge clock_in);
        #1;
        cfg_rst_n_out = 1'b1;
    endtask
endmodule

// >>> verif/tb_lane_switch_route_control.sv
// self-checking bench for the lane switch route control
`timescale 1ns/1ns
module tb_lane_switch_route_control;
    logic              clock;
    logic              nrst;
    logic              mode, sel, dual, cfg_rst_n, ptr_wr, data_wr;
    logic [2:0]        lb, eq, pe, idle, boost;
    logic [7:0]        wdata, rdata;
    lsr_pkg::lsr_src_e src_a, src_b, src_c;
    logic [1:0]        em_a, em_b, em_c;
    logic [7:0]        sh [5];
    int                errors, n_checks, cycles;

    lsr_ctrl_model u_m (.clock_in(clock), .mode_out(mode), .sel_out(sel),
        .dual_out(dual), .loop_out(lb), .boost_out(eq), .emph_out(pe),
        .cfg_rst_n_out(cfg_rst_n), .ptr_wr_out(ptr_wr),
        .data_wr_out(data_wr), .data_out(wdata));

    lsr_route_ctrl u_dut (.clock_in(clock), .nrst_in(nrst),
        .mode_pin_in(mode), .sel_pin_in(sel), .dual_copy_pin_in(dual),
        .port_a_loop_enable_in(lb[0]), .port_b_loop_enable_in(lb[1]),
        .port_c_loop_enable_in(lb[2]), .port_a_rx_boost_in(eq[0]),
        .port_b_rx_boost_in(eq[1]), .port_c_rx_boost_in(eq[2]),
        .port_a_tx_emphasis_in(pe[0]), .port_b_tx_emphasis_in(pe[1]),
        .port_c_tx_emphasis_in(pe[2]), .config_reset_n_in(cfg_rst_n),
        .reg_ptr_wr_in(ptr_wr), .reg_data_wr_in(data_wr),
        .reg_data_in(wdata), .out_a_src_out(src_a), .out_b_src_out(src_b),
        .out_c_src_out(src_c), .port_a_idle_out(idle[0]),
        .port_b_idle_out(idle[1]), .port_c_idle_out(idle[2]),
        .port_a_rx_boost_out(boost[0]), .port_b_rx_boost_out(boost[1]),
        .port_c_rx_boost_out(boost[2]), .port_a_tx_emphasis_out(em_a),
        .port_b_tx_emphasis_out(em_b), .port_c_tx_emphasis_out(em_c),
        .reg_rdata_out(rdata));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic results;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic settle;
        repeat (8) @(posedge clock);
        #2;
    endtask

    // expected outputs from pins, mode and shadow registers
    task automatic check_all;
        logic              s, d, dis;
        logic [2:0]        l;
        lsr_pkg::lsr_src_e es [3];
        lsr_pkg::lsr_src_e sr [3];
        logic [1:0]        em [3];
        s = (mode && sh[0][3]) ? sh[4][0] : sel;
        d = (mode && sh[0][4]) ? sh[4][1] : dual;
        for (int i = 0; i < 3; i++) begin
            l[i] = (mode && sh[0][i]) ? sh[i+1][3] : lb[i];
        end
        es[0] = l[0] ? lsr_pkg::LSR_SRC_A : (!s || d) ? lsr_pkg::LSR_SRC_C
              : lsr_pkg::LSR_SRC_IDLE;
        es[1] = l[1] ? lsr_pkg::LSR_SRC_B : (s || d) ? lsr_pkg::LSR_SRC_C
              : lsr_pkg::LSR_SRC_IDLE;
        es[2] = l[2] ? lsr_pkg::LSR_SRC_C : s ? lsr_pkg::LSR_SRC_B
              : lsr_pkg::LSR_SRC_A;
        sr[0] = src_a;
        sr[1] = src_b;
        sr[2] = src_c;
        em[0] = em_a;
        em[1] = em_b;
        em[2] = em_c;
        for (int i = 0; i < 3; i++) begin
            dis = mode && sh[i+1][4];
            check(sr[i], dis ? lsr_pkg::LSR_SRC_IDLE : es[i]);
            check(idle[i], dis || es[i] == lsr_pkg::LSR_SRC_IDLE);
            check(boost[i], mode ? sh[i+1][2] : eq[i]);
            check(em[i], mode ? sh[i+1][1:0] : (pe[i] ? 2'h2 : 2'h0));
        end
    endtask

    task automatic setp(input logic [11:0] v);
        u_m.pins(v);
        settle();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_m.strobe(1'b1, a);
        u_m.strobe(1'b0, d);
        if (a < 8'h05) begin
            sh[a] = d & (a == 8'h00 ? lsr_pkg::MASK_WMASK
                : a == 8'h04 ? lsr_pkg::ROUTE_WMASK : lsr_pkg::CFG_WMASK);
        end
    endtask

    task automatic rd(input logic [7:0] a);
        u_m.strobe(1'b1, a);
        repeat (3) @(posedge clock);
        #2;
        check(rdata, a < 8'h05 ? sh[a] : 8'h00);
    endtask

    task automatic t_pins;
        for (int i = 0; i < 32; i++) begin
            setp({1'b0, i[3], i[4], i[2:0], ~i[2:0], i[2:0]});
            check_all();
        end
    endtask

    task automatic t_serial;
        setp(12'hFFF);
        for (int k = 0; k < 4; k++) begin
            wr(8'h01, 8'(k));
            wr(8'h02, 8'(k ^ 5));
            wr(8'h03, 8'(k ^ 6));
            settle();
            check_all();
        end
    endtask

    task automatic t_mask;
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h08);
        wr(8'h04, 8'h01);
        setp(12'h800);
        wr(8'h00, 8'h0C);
        settle();
        check_all();
        wr(8'h00, 8'h1F);
        settle();
        check_all();
        setp(12'hAC0);
        check_all();
    endtask

    task automatic t_disable;
        wr(8'h00, 8'h00);
        for (int p = 1; p < 4; p++) wr(8'(p), 8'h10);
        setp(12'h800);
        check_all();
        setp(12'h000);
        check_all();
    endtask

    task automatic t_readback;
        setp(12'h800);
        for (int a = 0; a < 5; a++) rd(8'(a));
        wr(8'h04, 8'hFF);
        rd(8'h04);
        repeat (20) @(posedge clock);
        #2;
        check(rdata, 8'h03);
        wr(8'h07, 8'h55);
        rd(8'h07);
    endtask

    task automatic t_cfg_reset;
        wr(8'h02, 8'h1B);
        u_m.cfg_reset(8);
        for (int a = 0; a < 5; a++) sh[a] = 8'h00;
        repeat (10) @(posedge clock);
        #2;
        check(rdata, 8'h00);
        check_all();
        rd(8'h02);
    endtask

    initial begin
        nrst = 1'b0;
        errors = 0;
        n_checks = 0;
        cycles = 0;
        for (int a = 0; a < 5; a++) sh[a] = 8'h00;
        repeat (8) @(posedge clock);
        #1;
        check(idle, 3'h7);
        check(src_b, lsr_pkg::LSR_SRC_IDLE);
        check(rdata, 8'h00);
        nrst = 1'b1;
        repeat (12) @(posedge clock);
        t_pins();
        t_serial();
        t_mask();
        t_disable();
        t_readback();
        t_cfg_reset();
        results();
    end
endmodule
